/* File: rtl/ffp_frontend.sv */
// Purpose: Fetch realigner, instruction queue, predecoder and predictors.
// Assumes: Cache blocks, flush and execute feedback come from sys_clk logic.
// Notes: Predictions are looked up on the instruction being emitted.
// How it works
// RQ1: Each 32-bit block yields up to two instructions.
// RQ2: Straddling full instruction needs two blocks.
// RQ3: At most one instruction emitted per cycle.
// RQ4: Fragment held; completed later, flagged unaligned.
// RQ5: Flush, mispredict, replay, predict reset alignment.
// RQ6: Queue stores instr, kind, fault, addresses.
// RQ7: Decode pops by handshake; pop reported consumed.
// RQ8: Queue holds at most four instructions.
// RQ9: Only page fault recorded as exception.
// RQ10: Push while full raises replay with address.
// RQ11: Flush empties queue and pending fetch.
// RQ12: Predecode kind, compression, immediate.
// RQ13: History table of 1024 entries updated.
// RQ14: Two-bit counters indexed by virtual PC.
// RQ15: History updates ignored in debug mode.
// RQ16: History hit gives valid, taken, target.
// RQ17: Mispredicted indirect jumps fill 8-entry buffer.
// RQ18: Target buffer updates ignored in debug mode.
// RQ19: Target buffer lookup gives hit and target.
// RQ20: Stack and target buffer never flushed.
// RQ21: Direct call push return address; depth two.
// RQ22: Return lookup gives valid and stack top.
// RQ23: Counter saturates; upper bit predicts taken.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ffp_frontend #(
  parameter int QDEPTH = ffp_pkg::QUEUE_DEPTH,
  parameter int BHT_N = ffp_pkg::BHT_ENTRIES,
  parameter int BTB_N = ffp_pkg::BTB_ENTRIES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic debugMode,
  input wire logic flush,
  input wire logic mispredict,
  input wire logic blkValid,
  input wire logic [31:0] blkAddr,
  input wire logic [31:0] blkData,
  input wire logic blkPageFault,
  output logic blkReady,
  output logic servingUnaligned,
  output logic predictValid,
  output logic [31:0] predictTarget,
  output logic replay,
  output logic [31:0] replayAddr,
  output ffp_pkg::ffp_entry_t entry,
  output logic entryValid,
  input wire logic entryReady,
  output logic consumed,
  input wire ffp_pkg::ffp_bht_upd_t bhtUpdate,
  input wire ffp_pkg::ffp_btb_upd_t btbUpdate,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ffp_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ffp_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import ffp_pkg::*;

  localparam int QPW = $clog2(QDEPTH);
  localparam int QCW = $clog2(QDEPTH + 1);
  localparam int BHW = $clog2(BHT_N);
  localparam int BTW = $clog2(BTB_N);

  function automatic logic isShort(input logic [15:0] h);
    isShort = (h[1:0] != 2'b11);
  endfunction

  function automatic logic isLink(input logic [4:0] r);
    isLink = (r == 5'h01) || (r == 5'h05);
  endfunction

  function automatic ffp_scan_t scan(input logic [31:0] i);
    ffp_scan_t s;
    s = '0;
    s.compressed = isShort(i[15:0]);
    if (!s.compressed) begin
      case (i[6:0])
        7'h63: begin
          s.branch = 1'b1;
          s.imm = {{20{i[31]}}, i[7], i[30:25], i[11:8], 1'b0};
        end
        7'h6f: begin
          s.jump = 1'b1;
          s.call = isLink(i[11:7]);
          s.imm = {{12{i[31]}}, i[19:12], i[20], i[30:21], 1'b0};
        end
        7'h67: begin
          s.ret = (i[11:7] == 5'h00) && isLink(i[19:15]);
          s.jalr = !s.ret;
          s.call = isLink(i[11:7]);
          s.imm = {{20{i[31]}}, i[31:20]};
        end
        default: begin
          s.imm = '0;
        end
      endcase
    end else if (i[1:0] == 2'b01) begin
      case (i[15:13])
        3'h1, 3'h5: begin
          s.jump = 1'b1;
          s.call = (i[15:13] == 3'h1);
          s.imm = {{21{i[12]}}, i[8], i[10:9], i[6], i[7], i[2], i[11], i[5:3], 1'b0};
        end
        3'h6, 3'h7: begin
          s.branch = 1'b1;
          s.imm = {{24{i[12]}}, i[6:5], i[2], i[11:10], i[4:3], 1'b0};
        end
        default: begin
          s.imm = '0;
        end
      endcase
    end else if (i[1:0] == 2'b10 && i[15:13] == 3'h4 && i[6:2] == 5'h00 && i[11:7] != 5'h00) begin
      if (!i[12]) begin
        s.shortRegJumpFlag = 1'b1;
        s.ret = isLink(i[11:7]);
        s.jalr = !s.ret;
      end else begin
        s.jalr = 1'b1;
        s.call = 1'b1;
      end
    end
    return s;
  endfunction

  // Realigner state
  logic curValid_q;
  logic [31:0] curData_q;
  logic [31:0] curAddr_q;
  logic curOff_q;
  logic curFault_q;
  logic fragValid_q;
  logic [15:0] frag_q;
  logic [31:0] fragAddr_q;
  logic [31:0] ctrl_q;

  logic emitValid;
  logic [31:0] emitInstr;
  logic [31:0] emitAddr;
  logic emitFault;
  logic lastStep;
  logic storeFrag;
  logic acceptBlk;
  logic realignClear;
  logic predTaken;

  always_comb begin
    emitValid = 1'b0;
    emitInstr = '0;
    emitAddr = curAddr_q;
    emitFault = 1'b0;
    servingUnaligned = 1'b0;
    lastStep = 1'b0;
    storeFrag = 1'b0;
    if (curValid_q) begin
      if (curFault_q) begin
        emitValid = 1'b1;
        emitFault = 1'b1;
        lastStep = 1'b1;
      end else if (fragValid_q) begin
        emitValid = 1'b1; // [RQ4]
        emitInstr = {curData_q[15:0], frag_q}; // [RQ2]
        emitAddr = fragAddr_q;
        servingUnaligned = 1'b1; // [RQ4]
      end else if (!curOff_q) begin
        emitValid = 1'b1;
        if (isShort(curData_q[15:0])) begin
          emitInstr = {16'h0000, curData_q[15:0]}; // [RQ1]
        end else begin
          emitInstr = curData_q;
          lastStep = 1'b1;
        end
      end else begin
        lastStep = 1'b1;
        if (isShort(curData_q[31:16])) begin
          emitValid = 1'b1; // [RQ1]
          emitInstr = {16'h0000, curData_q[31:16]};
          emitAddr = curAddr_q + 32'h2;
        end else begin
          storeFrag = 1'b1; // [RQ2]
        end
      end
    end
  end

  // One step per cycle bounds the emit rate to a single instruction
  assign blkReady = !curValid_q || lastStep; // [RQ3]
  assign acceptBlk = blkValid && blkReady;

  // Queue state
  ffp_entry_t mem_q [QDEPTH];
  logic [QPW-1:0] wrPtr_q;
  logic [QPW-1:0] rdPtr_q;
  logic [QCW-1:0] count_q;
  logic qFull;
  logic push;
  logic pop;

  assign entryValid = (count_q != '0);
  assign entry = mem_q[rdPtr_q];
  assign pop = entryValid && entryReady; // [RQ7]
  assign consumed = pop; // [RQ7]
  // A pop in the same cycle frees the slot, so no needless replay
  assign qFull = (count_q == QCW'(QDEPTH)) && !pop; // [RQ8]
  assign replay = emitValid && qFull; // [RQ10]
  assign replayAddr = emitAddr; // [RQ10]
  assign push = emitValid && !qFull && !flush;
  assign realignClear = flush || mispredict || replay || predTaken; // [RQ5]

  always_ff @(posedge sys_clk) begin
    if (rst || realignClear) begin
      curValid_q <= 1'b0; // [RQ5]
      curData_q <= '0;
      curAddr_q <= '0;
      curOff_q <= 1'b0;
      curFault_q <= 1'b0;
    end else if (acceptBlk) begin
      curValid_q <= 1'b1;
      curData_q <= blkData;
      curAddr_q <= {blkAddr[31:2], 2'b00};
      curOff_q <= blkAddr[1];
      curFault_q <= blkPageFault;
    end else if (lastStep) begin
      curValid_q <= 1'b0;
    end else if (emitValid) begin
      curOff_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || realignClear) begin
      fragValid_q <= 1'b0; // [RQ5]
      frag_q <= '0;
      fragAddr_q <= '0;
    end else if (storeFrag) begin
      fragValid_q <= 1'b1; // [RQ4]
      frag_q <= curData_q[31:16];
      fragAddr_q <= curAddr_q + 32'h2;
    end else if (servingUnaligned) begin
      fragValid_q <= 1'b0;
    end
  end

  // Predecode and prediction lookup
  ffp_scan_t sc;
  logic [2:0] kind;
  logic [31:0] seqAddr;
  logic [31:0] relTarget;
  logic predEn;
  logic [1:0] ctr_q [BHT_N];
  logic bhtValid_q [BHT_N];
  logic btbValid_q [BTB_N];
  logic [31:0] btbPc_q [BTB_N];
  logic [31:0] btbTarget_q [BTB_N];
  logic [31:0] rasAddr_q [RAS_DEPTH];
  logic rasValid_q [RAS_DEPTH];
  logic [BHW-1:0] bhtLook;
  logic [BTW-1:0] btbLook;
  logic bhtHit;
  logic bhtTaken;
  logic btbHit;
  logic rasHit;
  logic rasPush;
  logic rasPop;

  assign sc = scan(emitInstr); // [RQ12]
  assign predEn = ctrl_q[CTRL_PRED_EN_BIT];
  assign seqAddr = emitAddr + (sc.compressed ? 32'h2 : 32'h4);
  assign relTarget = emitAddr + sc.imm;
  assign bhtLook = emitAddr[BHW:1]; // [RQ14]
  assign btbLook = emitAddr[BTW:1];
  assign bhtHit = bhtValid_q[bhtLook]; // [RQ16]
  assign bhtTaken = ctr_q[bhtLook][1]; // [RQ23]
  assign btbHit = btbValid_q[btbLook] && (btbPc_q[btbLook] == emitAddr); // [RQ19]
  assign rasHit = rasValid_q[0]; // [RQ22]

  always_comb begin
    kind = CF_NONE;
    if (sc.branch) begin
      kind = CF_BRANCH;
    end else if (sc.jump) begin
      kind = CF_JUMP;
    end else if (sc.ret) begin
      kind = CF_RETURN;
    end else if (sc.jalr) begin
      kind = CF_JALR;
    end
  end

  always_comb begin
    predTaken = 1'b0;
    predictTarget = seqAddr;
    rasPop = 1'b0;
    if (push && !emitFault && predEn) begin
      if (sc.jump) begin
        predTaken = 1'b1;
        predictTarget = relTarget;
      end else if (sc.branch && bhtHit && bhtTaken) begin
        predTaken = 1'b1; // [RQ16]
        predictTarget = relTarget;
      end else if (sc.ret && rasHit) begin
        predTaken = 1'b1; // [RQ22]
        predictTarget = rasAddr_q[0];
        rasPop = 1'b1;
      end else if (sc.jalr && btbHit) begin
        predTaken = 1'b1; // [RQ19]
        predictTarget = btbTarget_q[btbLook];
      end
    end
  end

  assign predictValid = predTaken;
  assign rasPush = push && !emitFault && sc.jump && sc.call; // [RQ21]

  // Queue storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wrPtr_q].instr <= emitInstr; // [RQ6]
      mem_q[wrPtr_q].addr <= emitAddr;
      mem_q[wrPtr_q].controlFlowKind <= emitFault ? CF_NONE : kind;
      mem_q[wrPtr_q].pageFault <= emitFault; // [RQ9]
      mem_q[wrPtr_q].excAddr <= emitFault ? emitAddr : '0;
      mem_q[wrPtr_q].predictAddr <= predictTarget;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || flush) begin
      wrPtr_q <= '0; // [RQ11]
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == QPW'(QDEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == QPW'(QDEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // History table; no flush path by design
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int k = 0; k < BHT_N; k++) begin
        ctr_q[k] <= CTR_RESET;
        bhtValid_q[k] <= 1'b0;
      end
    end else if (bhtUpdate.valid && !debugMode) begin // [RQ15]
      bhtValid_q[bhtUpdate.pc[BHW:1]] <= 1'b1; // [RQ13]
      if (bhtUpdate.taken && ctr_q[bhtUpdate.pc[BHW:1]] != CTR_MAX) begin
        ctr_q[bhtUpdate.pc[BHW:1]] <= ctr_q[bhtUpdate.pc[BHW:1]] + 2'h1; // [RQ23]
      end else if (!bhtUpdate.taken && ctr_q[bhtUpdate.pc[BHW:1]] != CTR_MIN) begin
        ctr_q[bhtUpdate.pc[BHW:1]] <= ctr_q[bhtUpdate.pc[BHW:1]] - 2'h1; // [RQ14]
      end
    end
  end

  // Target buffer keeps entries across flushes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int k = 0; k < BTB_N; k++) begin
        btbValid_q[k] <= 1'b0; // [RQ20]
        btbPc_q[k] <= '0;
        btbTarget_q[k] <= '0;
      end
    end else if (btbUpdate.valid && !debugMode) begin // [RQ18]
      btbValid_q[btbUpdate.pc[BTW:1]] <= 1'b1; // [RQ17]
      btbPc_q[btbUpdate.pc[BTW:1]] <= btbUpdate.pc;
      btbTarget_q[btbUpdate.pc[BTW:1]] <= btbUpdate.target;
    end
  end

  // Two-deep stack; the older entry drops off on overflow
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int k = 0; k < RAS_DEPTH; k++) begin
        rasAddr_q[k] <= '0; // [RQ20]
        rasValid_q[k] <= 1'b0;
      end
    end else if (rasPush) begin
      rasAddr_q[0] <= seqAddr; // [RQ21]
      rasValid_q[0] <= 1'b1;
      rasAddr_q[1] <= rasAddr_q[0];
      rasValid_q[1] <= rasValid_q[0];
    end else if (rasPop) begin
      rasAddr_q[0] <= rasAddr_q[1];
      rasValid_q[0] <= rasValid_q[1];
      rasAddr_q[1] <= '0;
      rasValid_q[1] <= 1'b0;
    end
  end

  // AXI4-Lite slave
  logic awHeld_q;
  logic [AXI_ADDR_W-1:0] awAddr_q;
  logic wHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  logic [31:0] statusWord;

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  always_comb begin
    statusWord = '0;
    statusWord[STATUS_COUNT_LSB +: QCW] = count_q;
    statusWord[STATUS_FULL_BIT] = (count_q == QCW'(QDEPTH));
    statusWord[STATUS_FRAG_BIT] = fragValid_q;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
      wHeld_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      if (awAddr_q[AXI_ADDR_W-1:2] == CTRL_OFFSET[AXI_ADDR_W-1:2]) begin
        s_axi_bresp <= RESP_OKAY;
        if (wStrb_q[0]) begin
          ctrl_q[CTRL_PRED_EN_BIT] <= wData_q[CTRL_PRED_EN_BIT];
        end
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr[AXI_ADDR_W-1:2] == CTRL_OFFSET[AXI_ADDR_W-1:2]) begin
        s_axi_rdata <= ctrl_q;
      end else if (s_axi_araddr[AXI_ADDR_W-1:2] == STATUS_OFFSET[AXI_ADDR_W-1:2]) begin
        s_axi_rdata <= statusWord;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/ffp_pkg.sv */
// Purpose: Shared constants and carriers for the fetch front end.
// Assumes: 32-bit addresses and instructions.
// Notes: Register offsets are byte addresses on the AXI4-Lite slave.
package ffp_pkg;
  localparam int XLEN = 32;
  localparam int QUEUE_DEPTH = 4;
  localparam int BHT_ENTRIES = 1024;
  localparam int BTB_ENTRIES = 8;
  localparam int RAS_DEPTH = 2;
  localparam int AXI_ADDR_W = 8;

  // Control-flow kinds stored with each queued instruction
  localparam logic [2:0] CF_NONE = 3'h0;
  localparam logic [2:0] CF_BRANCH = 3'h1;
  localparam logic [2:0] CF_JUMP = 3'h2;
  localparam logic [2:0] CF_JALR = 3'h3;
  localparam logic [2:0] CF_RETURN = 3'h4;

  localparam logic [1:0] CTR_RESET = 2'h1;
  localparam logic [1:0] CTR_MAX = 2'h3;
  localparam logic [1:0] CTR_MIN = 2'h0;

  localparam logic [AXI_ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam int CTRL_PRED_EN_BIT = 0;
  localparam int STATUS_COUNT_LSB = 0;
  localparam int STATUS_FULL_BIT = 4;
  localparam int STATUS_FRAG_BIT = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] instr;
    logic [31:0] addr;
    logic [2:0] controlFlowKind;
    logic pageFault;
    logic [31:0] excAddr;
    logic [31:0] predictAddr;
  } ffp_entry_t;

  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic taken;
  } ffp_bht_upd_t;

  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic [31:0] target;
  } ffp_btb_upd_t;

  typedef struct packed {
    logic compressed;
    logic branch;
    logic jump;
    logic jalr;
    logic ret;
    logic call;
    logic shortRegJumpFlag;
    logic [31:0] imm;
  } ffp_scan_t;
endpackage

/* File: test/ffp_cache_model.sv */
// Purpose: Cache and decode stand-in for the fetch front end.
// Assumes: Bench queues blocks; mode 0 ready, 1 random stall, 2 stalled.
// Notes: Idle data toggles so a stale block never looks valid.
`timescale 1ns/1ps
`default_nettype none
module ffp_cache_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic blkReady,
  input wire logic [1:0] mode,
  output logic blkValid,
  output logic [31:0] blkAddr,
  output logic [31:0] blkData,
  output logic blkPageFault,
  output logic entryReady
);
  logic [64:0] q[$];
  initial begin
    blkValid = 0;
    blkAddr = '0;
    blkData = '0;
    blkPageFault = 0;
    entryReady = 0;
  end
  always @(posedge sys_clk) begin
    if (blkValid && blkReady && !rst) begin
      void'(q.pop_front());
    end
    if (q.size() != 0 && !rst) begin
      {blkPageFault, blkAddr, blkData} <= q[0];
    end else begin
      blkData <= ~blkData;
    end
    blkValid <= !rst && q.size() != 0;
    entryReady <= mode == 2'h0 || (mode == 2'h1 && $urandom_range(1, 0) == 1);
  end
endmodule
`default_nettype wire

/* File: test/ffp_frontend_properties.sv */
// Purpose: Concurrent checks on the fetch front end ports.
// Assumes: Single sys_clk domain, synchronous active-high rst.
// Notes: Bound to every ffp_frontend instance.
`timescale 1ns/1ps
`default_nettype none
module ffp_frontend_properties
  import ffp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic mispredict,
  input wire logic servingUnaligned,
  input wire logic replay,
  input wire ffp_pkg::ffp_entry_t entry,
  input wire logic entryValid,
  input wire logic entryReady,
  input wire logic consumed,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_pop;
    consumed == (entryValid && entryReady);
  endproperty
  a_pop: assert property (p_pop) else $error("consumed differs from handshake");
  property p_hold;
    entryValid && !entryReady && !flush |=> entryValid && $stable(entry);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled entry changed");
  property p_flush;
    flush |=> !entryValid;
  endproperty
  a_flush: assert property (p_flush) else $error("queue not empty after flush");
  property p_realign;
    (flush || mispredict) |=> !servingUnaligned;
  endproperty
  a_realign: assert property (p_realign) else $error("fragment kept after redirect");
  property p_unal;
    servingUnaligned && !replay && !flush |=> entryValid;
  endproperty
  a_unal: assert property (p_unal) else $error("unaligned instruction not queued");
  property p_replay;
    replay && !flush |-> entryValid;
  endproperty
  a_replay: assert property (p_replay) else $error("replay with empty queue");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rsp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("read data late");
  property p_one;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_one: assert property (p_one) else $error("second write taken");
  c_replay: cover property (replay);
  c_unal: cover property (servingUnaligned);
  c_b2b: cover property (consumed ##1 consumed);
endmodule
bind ffp_frontend ffp_frontend_properties u_chk (.*);
`default_nettype wire

/* File: test/ffp_frontend_tb.sv */
// Purpose: Self-checking bench for the fetch front end.
// Assumes: Expected entries are queued by the scenarios, in order.
// Notes: Kind code 7 in an expected entry means any kind.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module ffp_frontend_tb;
  import ffp_pkg::*;
  logic sys_clk = 0, rst = 1, debugMode = 0, flush = 0, mispredict = 0;
  logic blkValid, blkPageFault, blkReady, servingUnaligned, predictValid, replay, entryValid, entryReady, consumed;
  logic [31:0] blkAddr, blkData, predictTarget, replayAddr, rv, a, d;
  ffp_entry_t entry, want;
  ffp_bht_upd_t bhtUpdate = '0;
  ffp_btb_upd_t btbUpdate = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, mode = 0;
  int n_mismatch = 0, checked = 0, i;
  ffp_entry_t expQ[$];
  logic [31:0] pq[$], rpq[$];
  always #5 sys_clk = ~sys_clk;
  ffp_frontend uut (.*);
  ffp_cache_model cm (.*);
  task report_and_stop;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task ex(input logic [31:0] ins, input logic [31:0] ad, input logic [2:0] k, input logic pf = 1'b0,
    input logic [31:0] pa = '0);
    expQ.push_back('{instr: ins, addr: ad, controlFlowKind: k, pageFault: pf, excAddr: ad & ~32'h3,
      predictAddr: (pa != 0) ? pa : ad + ((ins[1:0] == 2'b11) ? 32'h4 : 32'h2)});
  endtask
  task blk(input logic [31:0] ad, input logic [31:0] dt, input logic pf = 1'b0);
    cm.q.push_back({pf, ad, dt});
  endtask
  task settle;
    while (cm.q.size() != 0 || blkValid) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awvalid <= 1;
    s_axi_awaddr <= ad;
    s_axi_wvalid <= 1;
    s_axi_wdata <= dt;
    s_axi_wstrb <= 4'hf;
    s_axi_bready <= 1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_arvalid <= 1;
    s_axi_araddr <= ad;
    s_axi_rready <= 1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    dt = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task bht(input logic [31:0] pc, input logic t);
    @(posedge sys_clk);
    bhtUpdate <= '{1'b1, pc, t};
    @(posedge sys_clk);
    bhtUpdate <= '0;
  endtask
  task btb(input logic [31:0] pc, input logic [31:0] tg);
    @(posedge sys_clk);
    btbUpdate <= '{1'b1, pc, tg};
    @(posedge sys_clk);
    btbUpdate <= '0;
  endtask
  task predicted(input logic [31:0] tg);
    settle();
    `CHK(pq.size(), 1);
    rv = pq.pop_front();
    `CHK(rv, tg);
  endtask
  always @(posedge sys_clk) begin
    if (!rst && predictValid) pq.push_back(predictTarget);
    if (!rst && replay) rpq.push_back(replayAddr);
    if (!rst && consumed) begin
      want = expQ.pop_front();
      if (!want.pageFault) `CHK(entry.instr, want.instr);
      if (!want.pageFault) `CHK(entry.predictAddr, want.predictAddr);
      `CHK(entry.addr, want.addr);
      `CHK(entry.pageFault, want.pageFault);
      if (want.pageFault) `CHK(entry.excAddr, want.excAddr);
      if (want.controlFlowKind != 3'h7) `CHK(entry.controlFlowKind, want.controlFlowKind);
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    rv = $urandom(32'h3ec01b0d);
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    rd(CTRL_OFFSET, d, rr);
    `CHK(d, CTRL_RESET);
    rd(8'h40, d, rr);
    `CHK({rr, d}, {RESP_SLVERR, 32'h0});
    wr(STATUS_OFFSET, 32'h0, rr);
    `CHK(rr, RESP_SLVERR);
    wr(CTRL_OFFSET, 32'h0, rr);
    rd(CTRL_OFFSET, d, rr);
    `CHK({rr, d}, {RESP_OKAY, 32'h0});
    $display("test registers done");
    blk(32'h100, 32'h4505_0001);
    ex(32'h1, 32'h100, CF_NONE);
    ex(32'h4505, 32'h102, CF_NONE);
    blk(32'h104, 32'h0010_0093);
    ex(32'h0010_0093, 32'h104, CF_NONE);
    blk(32'h108, 32'h0113_0001);
    blk(32'h10c, 32'h0001_0020);
    ex(32'h1, 32'h108, CF_NONE);
    ex(32'h0020_0113, 32'h10a, CF_NONE);
    ex(32'h1, 32'h10e, CF_NONE);
    blk(32'h110, $urandom, 1'b1);
    ex(32'h0, 32'h110, CF_NONE, 1'b1);
    a = 32'h140;
    for (i = 0; i < 12; i++) begin
      rv = $urandom;
      if (rv[0]) begin
        d = {rv[31:18], 2'b00, rv[15:2], 2'b00};
        ex({16'h0, d[15:0]}, a, CF_NONE);
        ex({16'h0, d[31:16]}, a + 2, CF_NONE);
      end else begin
        d = {rv[31:7], 7'h13};
        ex(d, a, CF_NONE);
      end
      blk(a, d);
      a = a + 4;
    end
    settle();
    `CHK(expQ.size(), 0);
    `CHK(pq.size(), 0);
    $display("test stream done");
    blk(32'h300, 32'h0113_0001);
    ex(32'h1, 32'h300, CF_NONE);
    settle();
    mispredict <= 1;
    @(posedge sys_clk);
    mispredict <= 0;
    blk(32'h400, 32'h0001_0001);
    ex(32'h1, 32'h400, CF_NONE);
    ex(32'h1, 32'h402, CF_NONE);
    settle();
    `CHK(expQ.size(), 0);
    $display("test realign reset done");
    mode <= 2;
    for (i = 0; i < 6; i++) begin
      blk(32'h500 + 4 * i, 32'h13 + (i << 7));
      if (i < 4) ex(32'h13 + (i << 7), 32'h500 + 4 * i, CF_NONE);
    end
    settle();
    `CHK(rpq.size(), 1);
    `CHK(rpq[0], 32'h510);
    rd(STATUS_OFFSET, d, rr);
    `CHK(d, 32'h14);
    mode <= 1;
    while (expQ.size() != 0) @(posedge sys_clk);
    $display("test replay done");
    mode <= 0;
    wr(CTRL_OFFSET, 32'h1, rr);
    blk(32'h200, 32'h0100_00ef);
    ex(32'h0100_00ef, 32'h200, CF_JUMP, 1'b0, 32'h210);
    predicted(32'h210);
    blk(32'h210, 32'h0000_8067);
    ex(32'h0000_8067, 32'h210, CF_RETURN, 1'b0, 32'h204);
    predicted(32'h204);
    for (i = 0; i < 3; i++) bht(32'h220, 1'b1);
    bht(32'h220, 1'b0);
    bht(32'h224, 1'b0);
    blk(32'h220, 32'h0000_0463);
    ex(32'h0000_0463, 32'h220, CF_BRANCH, 1'b0, 32'h228);
    predicted(32'h228);
    blk(32'h224, 32'h0000_0463);
    ex(32'h0000_0463, 32'h224, 3'h7);
    settle();
    `CHK(pq.size(), 0);
    btb(32'h240, 32'h300);
    blk(32'h240, 32'h0003_0067);
    ex(32'h0003_0067, 32'h240, CF_JALR, 1'b0, 32'h300);
    predicted(32'h300);
    debugMode <= 1;
    bht(32'h230, 1'b1);
    btb(32'h250, 32'h400);
    debugMode <= 0;
    blk(32'h230, 32'h0000_0463);
    ex(32'h0000_0463, 32'h230, 3'h7);
    blk(32'h250, 32'h0003_0067);
    ex(32'h0003_0067, 32'h250, 3'h7);
    settle();
    `CHK(pq.size(), 0);
    $display("test predictors done");
    mode <= 2;
    blk(32'h600, 32'h13);
    blk(32'h604, 32'h93);
    settle();
    flush <= 1;
    @(posedge sys_clk);
    flush <= 0;
    mode <= 0;
    expQ.delete();
    repeat (3) @(posedge sys_clk);
    `CHK(entryValid, 1'b0);
    blk(32'h240, 32'h0003_0067);
    ex(32'h0003_0067, 32'h240, CF_JALR, 1'b0, 32'h300);
    predicted(32'h300);
    `CHK(expQ.size(), 0);
    $display("test flush done");
    report_and_stop();
  end
endmodule
`default_nettype wire
